// file: pkg/pamt_regs.vh
// Purpose: constants for the page attribute memory type resolver
// Assumes: memory type codes are 8 bits wide in each table field
// Notes:   derived type codes above 8'h07 are internal result codes
`ifndef PAMT_REGS_VH
`define PAMT_REGS_VH

`define PAMT_TABLE_ADDR     32'h0000_0277
`define PAMT_FIELD_W        8
`define PAMT_FIELD_CNT      8
`define PAMT_FEATURE_BIT    16
`define PAMT_SMALL_ATTR_BIT 7
`define PAMT_LARGE_ATTR_BIT 12
`define PAMT_CD_BIT         4
`define PAMT_WT_BIT         3
`define PAMT_TABLE_RESET    64'h0000_0000_0000_0000
`define PAMT_RDATA_IDLE     64'h0000_0000_0000_0000
`define PAMT_FLAG_ONE       32'h0000_0001

// memory type codes held in the table and range registers
`define PAMT_UC             8'h00
`define PAMT_WC             8'h01
`define PAMT_WT             8'h04
`define PAMT_WP             8'h05
`define PAMT_WB             8'h06
`define PAMT_UCM            8'h07

// effective and final result codes, 4 bits
`define PAMT_R_UC           4'h0
`define PAMT_R_WC           4'h1
`define PAMT_R_WT           4'h4
`define PAMT_R_WP           4'h5
`define PAMT_R_WB           4'h6
`define PAMT_R_CD           4'h8
`define PAMT_R_UC_RANGE     4'h9
`define PAMT_R_UNCACHEABLE_PAGE      4'hA

`endif

// file: hw/pamt_field_check.v
// Purpose: flags an undefined memory type code in one table field
// Assumes: uncacheable_minus code is accepted as a page type
// Notes:   instantiated once per field of the table
`timescale 1ns/1ps
`include "pamt_regs.vh"

module pamt_field_check
(
	code,
	bad
);
	input  wire [7:0] code;
	output wire       bad;

	// only the five standard codes plus uncacheable_minus are legal
	assign bad = !((code == `PAMT_UC) || (code == `PAMT_WC) ||
		(code == `PAMT_WT) || (code == `PAMT_WP) ||
		(code == `PAMT_WB) || (code == `PAMT_UCM));
endmodule

// file: hw/pamt_resolver.v
// Purpose: page attribute table register and memory type resolution
// Assumes: register port is a model-specific register read/write port
// Notes:   result is registered, one cycle after the lookup inputs
// Function
// - table is one 64-bit register at address 277h
// - eight 8-bit fields, each a memory type code
// - write with undefined code is dropped and raises general protection
// - feature flag bit 16 reports table support
// - index is attr bit, cache-off bit, write-thru bit; attr bit 12 only, bit 7 never indexes
// - page type comes from the selected field, not the entry bits
// - extension on or small directory: 2-bit index, fields 0 to 3
// - page write-combining wins; page writeback passes range type
// - writethrough and write-protect page combos per range type
// - uncacheable_minus with range UC gives uncacheable_range, no probe
// - uncacheable_minus with other ranges gives uncacheable_page, probe
// - reserved combinations give cache_disabled
// - force_cache_off outputs cache_disabled, range type ignored
// - force_cache_off from four causes
// - read mem, write io: WT or WB become cache_disabled
// - write mem, read io: WT, WP, WB become cache_disabled
// - both io: WB becomes WT
// - codes 00,01,04,05,06,07 defined; others undefined
`timescale 1ns/1ps
`include "pamt_regs.vh"

module pamt_resolver
(
	clk,
	rstn,
	msr_addr,
	msr_wr,
	msr_rd,
	msr_wdata,
	msr_rdata,
	msr_hit,
	general_protection,
	feature_flags,
	lookup_valid,
	page_entry,
	large_page,
	phys_addr_extension,
	range_type,
	read_to_memory,
	write_to_memory,
	control_cache_off_bit,
	tlb_cache_off,
	clean_victim_wb,
	local_intc_access,
	final_valid,
	final_type,
	probe_caches,
	force_cache_off
);
	input  wire        clk;
	input  wire        rstn;
	input  wire [31:0] msr_addr;
	input  wire        msr_wr;
	input  wire        msr_rd;
	input  wire [63:0] msr_wdata;
	output reg  [63:0] msr_rdata;
	output wire        msr_hit;
	output reg         general_protection;
	output wire [31:0] feature_flags;
	input  wire        lookup_valid;
	input  wire [12:0] page_entry;
	input  wire        large_page;
	input  wire        phys_addr_extension;
	input  wire [7:0]  range_type;
	input  wire        read_to_memory;
	input  wire        write_to_memory;
	input  wire        control_cache_off_bit;
	input  wire        tlb_cache_off;
	input  wire        clean_victim_wb;
	input  wire        local_intc_access;
	output reg         final_valid;
	output reg  [3:0]  final_type;
	output reg         probe_caches;
	output wire        force_cache_off;

	reg  [63:0] page_attr_table;
	wire [7:0]  bad_field;
	wire        write_bad;
	reg  [2:0]  field_sel;
	reg  [7:0]  page_type;
	reg  [3:0]  eff_type;
	reg  [3:0]  next_final;
	wire        attr_index_bit;
	wire        page_cache_off_bit;
	wire        page_write_thru_bit;
	wire        short_index;

	assign msr_hit = (msr_addr == `PAMT_TABLE_ADDR);

	// one checker per field of the incoming write
	genvar gi;
	generate
		for (gi = 0; gi < `PAMT_FIELD_CNT; gi = gi + 1)
		begin : g_chk
			pamt_field_check u_chk
			(
				.code (msr_wdata[gi*`PAMT_FIELD_W +: `PAMT_FIELD_W]),
				.bad  (bad_field[gi])
			);
		end
	endgenerate

	assign write_bad = |bad_field;

	// table write; an illegal write leaves the table untouched
	always @(posedge clk)
	begin
		if (!rstn)
		begin
			page_attr_table    <= `PAMT_TABLE_RESET;
			general_protection <= 1'b0;
		end
		else
		begin
			// fault pulses one cycle, table keeps its old value
			general_protection <= msr_wr && msr_hit && write_bad;
			if (msr_wr && msr_hit && !write_bad)
			begin
				page_attr_table <= msr_wdata;
			end
		end
	end

	// read data registered; unmapped address reads zero
	always @(posedge clk)
	begin
		if (!rstn)
		begin
			msr_rdata <= `PAMT_RDATA_IDLE;
		end
		else if (msr_rd && msr_hit)
		begin
			msr_rdata <= page_attr_table;
		end
		else
		begin
			// zero when idle so a stale table never shows on the bus
			msr_rdata <= `PAMT_RDATA_IDLE;
		end
	end

	// only the table support flag is owned here
	assign feature_flags = `PAMT_FLAG_ONE << `PAMT_FEATURE_BIT;

	// attribute index bit sits at bit 7 or bit 12 by page size
	assign attr_index_bit = large_page ? page_entry[`PAMT_LARGE_ATTR_BIT]
		: page_entry[`PAMT_SMALL_ATTR_BIT];
	assign page_cache_off_bit  = page_entry[`PAMT_CD_BIT];
	assign page_write_thru_bit = page_entry[`PAMT_WT_BIT];

	// a small page directory bit 7 is the size bit, so it must not index
	assign short_index = phys_addr_extension || !large_page;

	// field select and page type lookup
	always @*
	begin
		if (short_index)
		begin
			// upper half of the table is unreachable in this mode
			field_sel = {1'b0, page_cache_off_bit,
				page_write_thru_bit};
		end
		else
		begin
			field_sel = {attr_index_bit, page_cache_off_bit,
				page_write_thru_bit};
		end
		page_type = page_attr_table[field_sel*`PAMT_FIELD_W +:
			`PAMT_FIELD_W];
	end

	// any single cause forces the cache off
	assign force_cache_off = control_cache_off_bit || tlb_cache_off ||
		clean_victim_wb || local_intc_access;

	// page type combined with range type
	always @*
	begin
		eff_type = `PAMT_R_CD;
		case (page_type)
			`PAMT_WC:
			begin
				// write-combining page overrides any range type
				eff_type = `PAMT_R_WC;
			end

			`PAMT_WB:
			begin
				// writeback page leaves the range type in charge
				case (range_type)
					`PAMT_WB:
					begin
						eff_type = `PAMT_R_WB;
					end
					`PAMT_UC:
					begin
						eff_type = `PAMT_R_UC;
					end
					`PAMT_WC:
					begin
						eff_type = `PAMT_R_WC;
					end
					`PAMT_WT:
					begin
						eff_type = `PAMT_R_WT;
					end
					`PAMT_WP:
					begin
						eff_type = `PAMT_R_WP;
					end
					default:
					begin
						eff_type = `PAMT_R_CD;
					end
				endcase
			end

			`PAMT_WT:
			begin
				// combining or protect ranges cannot be honoured here
				case (range_type)
					`PAMT_WB:
					begin
						eff_type = `PAMT_R_WT;
					end
					`PAMT_WT:
					begin
						eff_type = `PAMT_R_WT;
					end
					`PAMT_UC:
					begin
						eff_type = `PAMT_R_UC;
					end
					default:
					begin
						eff_type = `PAMT_R_CD;
					end
				endcase
			end

			`PAMT_WP:
			begin
				// uncacheable range keeps its no-probe marking
				case (range_type)
					`PAMT_WB:
					begin
						eff_type = `PAMT_R_WP;
					end
					`PAMT_WP:
					begin
						eff_type = `PAMT_R_WP;
					end
					`PAMT_UC:
					begin
						eff_type = `PAMT_R_UC_RANGE;
					end
					default:
					begin
						eff_type = `PAMT_R_CD;
					end
				endcase
			end

			`PAMT_UCM, `PAMT_UC:
			begin
				// page-sourced uncacheable may alias, range-sourced cannot
				case (range_type)
					`PAMT_UC:
					begin
						eff_type = `PAMT_R_UC_RANGE;
					end
					`PAMT_WB, `PAMT_WT, `PAMT_WP, `PAMT_WC:
					begin
						eff_type = `PAMT_R_UNCACHEABLE_PAGE;
					end
					default:
					begin
						eff_type = `PAMT_R_CD;
					end
				endcase
			end

			default:
			begin
				eff_type = `PAMT_R_CD;
			end
		endcase
	end

	// read/write target adjustment, force wins over everything
	always @*
	begin
		next_final = eff_type;
		if (force_cache_off)
		begin
			next_final = `PAMT_R_CD;
		end
		else if (read_to_memory && !write_to_memory)
		begin
			// cached lines cannot be written back to io
			if (eff_type == `PAMT_R_WT || eff_type == `PAMT_R_WB)
			begin
				next_final = `PAMT_R_CD;
			end
		end
		else if (!read_to_memory && write_to_memory)
		begin
			// reads from io cannot fill a cached line
			if (eff_type == `PAMT_R_WT || eff_type == `PAMT_R_WP ||
				eff_type == `PAMT_R_WB)
			begin
				next_final = `PAMT_R_CD;
			end
		end
		else if (!read_to_memory && !write_to_memory)
		begin
			// io lines may be cached but must never go dirty
			if (eff_type == `PAMT_R_WB)
			begin
				next_final = `PAMT_R_WT;
			end
		end
	end

	// result registered for the cache and bus side
	always @(posedge clk)
	begin
		if (!rstn)
		begin
			final_valid  <= 1'b0;
			final_type   <= `PAMT_R_CD;
			probe_caches <= 1'b0;
		end
		else
		begin
			final_valid  <= lookup_valid;
			final_type   <= next_final;
			// range-sourced uncacheable skips the probe for speed
			probe_caches <= (next_final != `PAMT_R_UC_RANGE);
		end
	end
endmodule

// file: verification/pamt_walker.sv
// Purpose: paging and tlb fill side that feeds lookups to the resolver
// Assumes: one lookup is presented and held until the next one
// Notes:   mode 0 large page, 1 small page, 2 large page with extension
`timescale 1ns/1ps
module pamt_walker
(
	input  wire        clk,
	output reg         lookup_valid,
	output reg  [12:0] page_entry,
	output reg         large_page,
	output reg         phys_addr_extension,
	output reg  [7:0]  range_type,
	output reg         read_to_memory,
	output reg         write_to_memory,
	output reg  [3:0]  causes
);
	// idle until the first lookup
	initial
	begin
		{lookup_valid, page_entry, large_page, phys_addr_extension} = 16'h0;
		{range_type, read_to_memory, write_to_memory, causes} = 14'h0;
	end
	// attr bit sits at 7 or 12; it is set only at the one the page size selects
	// short-index modes only ever reach the low four fields
	task fill(input [2:0] x, input [1:0] md, input [7:0] r, input [1:0] m,
		input [3:0] f);
	begin
		@(posedge clk);
		#1 lookup_valid = 1'b1;
		page_entry = {x[2] && md != 2'h1, 4'h0, x[2] && md == 2'h1,
			2'h0, x[1:0], 3'h0};
		large_page = md != 2'h1;
		phys_addr_extension = md == 2'h2;
		range_type = r;
		{read_to_memory, write_to_memory} = m;
		causes = f;
	end
	endtask
endmodule

// file: verification/pamt_chk.sv
// Purpose: bound assertions on the resolver ports
// Assumes: single clock, synchronous active-low reset
// Notes:   results lag their lookup by one cycle
`timescale 1ns/1ps
`include "pamt_regs.vh"
module pamt_chk
(
	input wire        clk, rstn, msr_wr, msr_hit, general_protection,
	input wire        lookup_valid, read_to_memory, write_to_memory,
	input wire        control_cache_off_bit, tlb_cache_off, final_valid,
	input wire        clean_victim_wb, local_intc_access, probe_caches,
	input wire        force_cache_off,
	input wire [31:0] msr_addr,
	input wire [3:0]  final_type
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// register decode and fault pulse
	chk_hit_decode: assert property
		(msr_hit == (msr_addr == `PAMT_TABLE_ADDR)) else $error("bad hit");
	chk_gp_cause: assert property
		(general_protection |-> $past(msr_wr && msr_hit)) else $error("bad gp");
	// force causes and their effect on the next result
	chk_force_or: assert property
		(force_cache_off == (control_cache_off_bit || tlb_cache_off ||
		clean_victim_wb || local_intc_access)) else $error("bad force");
	chk_force_cd: assert property
		(lookup_valid && force_cache_off |=> final_type == `PAMT_R_CD)
		else $error("force not cd");
	// io attributes demote cached types one cycle later
	chk_write_to_io_demote: assert property
		(lookup_valid && read_to_memory && !write_to_memory |=>
		final_type != `PAMT_R_WT && final_type != `PAMT_R_WB)
		else $error("cached type kept on io write");
	chk_read_to_io_demote: assert property
		(lookup_valid && !read_to_memory && write_to_memory |=>
		!(final_type inside {`PAMT_R_WT, `PAMT_R_WP, `PAMT_R_WB}))
		else $error("cached type kept on io read");
	chk_io_no_wb: assert property
		(lookup_valid && !read_to_memory && !write_to_memory |=>
		final_type != `PAMT_R_WB) else $error("writeback on io");
	chk_probe_range: assert property
		(final_valid && final_type == `PAMT_R_UC_RANGE |-> !probe_caches)
		else $error("probe on range uncacheable");
	// main scenarios
	cov_gp: cover property (general_protection);
	cov_page: cover property (final_type == `PAMT_R_UNCACHEABLE_PAGE);
	cov_force: cover property (lookup_valid && force_cache_off);
endmodule

bind pamt_resolver pamt_chk u_chk
(
	.clk, .rstn, .msr_wr, .msr_hit, .general_protection, .lookup_valid,
	.read_to_memory, .write_to_memory, .control_cache_off_bit,
	.tlb_cache_off, .final_valid, .clean_victim_wb, .local_intc_access,
	.probe_caches, .force_cache_off, .msr_addr, .final_type
);

// file: verification/tb.sv
// Purpose: self-checking bench for the resolver
// Assumes: inputs move 1 ns after the rising edge
// Notes:   table entry {field, range, rd/wr, force, expected}
`timescale 1ns/1ps
`include "pamt_regs.vh"
module tb;
	localparam [63:0] TBL = 64'h0504_0107_0501_0406;
	localparam [31:0] EX = 32'h541A_5146;
	localparam [23:0] TY [0:27] = '{
		24'h100300, 24'h101308, 24'h105308, 24'h104304, 24'h300309,
		24'h304308, 24'h301308, 24'h400309, 24'h40430A, 24'h200301,
		24'h204301, 24'h000300, 24'h001301, 24'h005305, 24'h002308,
		24'h006208, 24'h006108, 24'h006004, 24'h006306, 24'h306205,
		24'h306108, 24'h206101, 24'h206001, 24'h006318, 24'h006328,
		24'h006348, 24'h006388, 24'h006018};
	reg         clk, rstn, msr_wr, msr_rd;
	reg  [31:0] msr_addr;
	reg  [63:0] msr_wdata;
	wire [63:0] msr_rdata;
	wire [31:0] feature_flags;
	wire [12:0] page_entry;
	wire [7:0]  range_type;
	wire [3:0]  causes, final_type;
	wire        msr_hit, general_protection, lookup_valid, large_page;
	wire        phys_addr_extension, read_to_memory, write_to_memory;
	wire        final_valid, probe_caches, force_cache_off;
	integer     n_errors, n_checks, i, m;

	pamt_resolver dut
	(
		.clk, .rstn, .msr_addr, .msr_wr, .msr_rd, .msr_wdata, .msr_rdata,
		.msr_hit, .general_protection, .feature_flags, .lookup_valid,
		.page_entry, .large_page, .phys_addr_extension, .range_type,
		.read_to_memory, .write_to_memory,
		.control_cache_off_bit(causes[0]), .tlb_cache_off(causes[1]),
		.clean_victim_wb(causes[2]), .local_intc_access(causes[3]),
		.final_valid, .final_type, .probe_caches, .force_cache_off
	);
	pamt_walker pm
	(
		.clk, .lookup_valid, .page_entry, .large_page, .phys_addr_extension,
		.range_type, .read_to_memory, .write_to_memory, .causes
	);

	task chk(input string nm, input [63:0] e, input [63:0] g);
	begin
		n_checks = n_checks + 1;
		if (g !== e)
		begin
			n_errors = n_errors + 1;
			$display("Error %0s expected %0h seen %0h", nm, e, g);
		end
	end
	endtask
	// one register access; answer is settled when this returns
	task model_specific_register(input rd, input [31:0] a, input [63:0] d);
	begin
		@(posedge clk);
		#1 {msr_addr, msr_wdata, msr_wr, msr_rd} = {a, d, !rd, rd};
		@(posedge clk);
		#1 {msr_wr, msr_rd} = 2'h0;
	end
	endtask
	task look(input [23:0] c, input [1:0] md);
	begin
		pm.fill(c[22:20], md, c[19:12], c[9:8], c[7:4]);
		@(posedge clk);
		#1 chk("final_type", c[3:0], final_type);
		chk("probe", c[3:0] != `PAMT_R_UC_RANGE, probe_caches);
		chk("valid", 1'b1, final_valid);
		chk("force", c[7:4] != 4'h0, force_cache_off);
	end
	endtask
	task t_reset;
	begin
		repeat (4) @(posedge clk);
		#1 chk("reset type", `PAMT_R_CD, final_type);
		chk("reset valid", 1'b0, final_valid);
		chk("features", 32'h0001_0000, feature_flags);
		rstn = 1'b1;
		model_specific_register(1'b1, `PAMT_TABLE_ADDR, 64'h0);
		chk("table", `PAMT_TABLE_RESET, msr_rdata);
		$display("t_reset done");
	end
	endtask
	// bad codes in field 3 and field 7 must leave the table alone
	task t_reg;
	begin
		model_specific_register(1'b0, `PAMT_TABLE_ADDR, TBL);
		chk("gp", 1'b0, general_protection);
		model_specific_register(1'b0, `PAMT_TABLE_ADDR, TBL ^ 64'h0000_0000_0700_0000);
		chk("gp", 1'b1, general_protection);
		model_specific_register(1'b0, `PAMT_TABLE_ADDR, TBL ^ 64'h0D00_0000_0000_0000);
		chk("gp", 1'b1, general_protection);
		model_specific_register(1'b1, `PAMT_TABLE_ADDR, 64'h0);
		chk("table", TBL, msr_rdata);
		model_specific_register(1'b1, 32'h0000_0278, 64'h0);
		chk("unmapped", 64'h0, msr_rdata);
		$display("t_reg done");
	end
	endtask
	// range writeback passes each field's page type through, except the uncacheable_minus field, which gives uncacheable_page
	task t_index;
		reg [2:0] k;
	begin
		for (m = 0; m < 3; m = m + 1)
			for (i = 0; i < 8; i = i + 1)
			begin
				k = (m == 0) ? i[2:0] : {1'b0, i[1:0]};
				look({1'b0, i[2:0], 16'h0630, EX[4 * k +: 4]}, m[1:0]);
			end
		$display("t_index done");
	end
	endtask
	task t_types;
	begin
		for (i = 0; i < 28; i = i + 1)
			look(TY[i], 2'h0);
		$display("t_types done");
	end
	endtask
	task end_sim;
	begin
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask

	// 100 ns clock
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// cut a hang short; the tests need well under 300 cycles
	initial
	begin
		#200000;
		n_errors = n_errors + 1;
		$display("Error watchdog expected done seen timeout");
		end_sim;
	end
	// main sequence
	initial
	begin
		{rstn, msr_wr, msr_rd, msr_addr, msr_wdata} = 99'h0;
		n_errors = 0;
		n_checks = 0;
		t_reset;
		t_reg;
		t_index;
		t_types;
		end_sim;
	end
endmodule
